// *** src/plpe_pkg.sv ***
package plpe_pkg;
	// register map, byte addresses on the word bus
	localparam logic [31:0] ADDR_FORCE_UPPER   = 32'h00c50004;
	localparam logic [31:0] ADDR_FORCE_LOWER   = 32'h00c50008;
	localparam logic [31:0] ADDR_LEVEL_PENDING = 32'h00c5000c;
	localparam logic [31:0] ADDR_NORMAL_ENABLE = 32'h00c50010;
	localparam logic [31:0] ADDR_NORMAL_PEND   = 32'h00c50014;
	localparam logic [31:0] ADDR_FAST_ENABLE   = 32'h00c50018;
	localparam logic [31:0] ADDR_FAST_PEND     = 32'h00c5001c;
	localparam logic [31:0] ADDR_IRQ_STATUS    = 32'h00c50020;
	localparam logic [31:0] ADDR_IRQ_MASK      = 32'h00c50024;
	localparam logic [31:0] ADDR_SEL_FIRST     = 32'h00c50040;
	localparam logic [31:0] ADDR_SEL_LAST      = 32'h00c50067;

	// level select: one byte per source, four sources per word
	localparam int          SEL_PER_WORD = 4;
	localparam int          BYTE_W       = 8;
	localparam int          LVL_W        = 5;
	localparam int          NUM_LVL      = 32;
	localparam int          LOWER_SRC    = 32;
	localparam int          SEL_IDX_LSB  = 2;
	localparam int          SEL_IDX_W    = 4;

	// interrupt status / mask bit positions
	localparam int          EV_FAST_RISE   = 0;
	localparam int          EV_NORMAL_RISE = 1;
	localparam int          EV_W           = 2;

	localparam logic [31:0] RESET_WORD = 32'h00000000;
endpackage

// *** src/priority_level_pending_enable.sv ***
`timescale 1ns/1ps
// Contract
// R1 - level pending bit x set while any request at level x is asserted
// R2 - pending vector indexed by priority level, not by source number
// R3 - writes to the three pending registers change nothing, no error
// R4 - normal enable register, 32 bits read/write, reset zero
// R5 - enabling a level with live request raises normal request at once
// R6 - normal pending bit x set when enabled request at level x asserted
// R7 - fast enable register, 32 bits read/write, reset zero
// R8 - enabling a level with live request raises fast request at once
// R9 - level and normal pending read-only, showing live request state
// R10 - fast and normal pending are enable AND level pending
// R11 - normal request only while fast request negated
// R12 - each source picks one of 32 levels by 5-bit select, default 0
// R13 - software force bits ORed with source requests before level select
// R14 - pending vectors recomputed every cycle, at most one clock old
module priority_level_pending_enable
	import plpe_pkg::*;
#(
	parameter int NUM_SRC = 40
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// peripheral interrupt sources
	input  wire logic [NUM_SRC-1:0]  src_req,
	// register port
	input  wire logic [31:0]         addr,
	input  wire logic [31:0]         wr_data,
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	output logic      [31:0]         rd_data,
	// processor requests
	output logic                     fast_req,
	output logic                     normal_req,
	// block interrupt
	output logic                     irq
);

	localparam int UPPER_SRC = NUM_SRC - LOWER_SRC;
	localparam int SEL_WORDS = (NUM_SRC + SEL_PER_WORD - 1) / SEL_PER_WORD;

	typedef struct packed {
		logic [NUM_LVL-1:0]              level_pending;
		logic [NUM_LVL-1:0]              normal_pending;
		logic [NUM_LVL-1:0]              fast_pending;
		logic [NUM_LVL-1:0]              normal_enable;
		logic [NUM_LVL-1:0]              fast_enable;
		logic [LOWER_SRC-1:0]            force_lower;
		logic [UPPER_SRC-1:0]            force_upper;
		logic [NUM_SRC-1:0][LVL_W-1:0]   level_select;
		logic [EV_W-1:0]                 status;
		logic [EV_W-1:0]                 mask;
		logic                            fast_req;
		logic                            normal_req;
		logic                            irq;
		logic [31:0]                     rd_data;
	} state_t;

	state_t                          st_ff;
	state_t                          nxt_st;
	logic   [NUM_SRC-1:0]            eff_req;
	logic   [NUM_LVL-1:0][NUM_SRC-1:0] lvl_match;
	logic   [NUM_LVL-1:0]            lvl_hit;
	logic   [31:0]                   sel_off;
	logic   [SEL_IDX_W-1:0]          sel_idx;
	logic                            sel_hit;

	assign rd_data    = st_ff.rd_data;
	assign fast_req   = st_ff.fast_req;
	assign normal_req = st_ff.normal_req;
	assign irq        = st_ff.irq;

	////////////////////////////////////////////////////////////////////////
	// source to level mapping

	// force ORed in ahead of the level select
	assign eff_req = src_req | {st_ff.force_upper, st_ff.force_lower}; // R13

	// no edge detect: sources hold until serviced, so a pure OR suffices
	for (genvar l = 0; l < NUM_LVL; l++) begin : g_lvl
		for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
			assign lvl_match[l][s] = eff_req[s] &&
				(st_ff.level_select[s] == LVL_W'(l)); // R2 R12
		end
		assign lvl_hit[l] = |lvl_match[l]; // R1
	end

	assign sel_off = addr - ADDR_SEL_FIRST;
	assign sel_idx = sel_off[SEL_IDX_LSB +: SEL_IDX_W];
	assign sel_hit = (addr >= ADDR_SEL_FIRST) && (addr <= ADDR_SEL_LAST);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [EV_W-1:0] ev;
		logic [31:0]     rword;
		int              src;
		nxt_st = st_ff;
		ev     = '0;
		rword  = RESET_WORD;
		src    = 0;

		// register writes; pending registers have no write path
		if (wr_en) begin // R3
			if (addr == ADDR_NORMAL_ENABLE) begin
				nxt_st.normal_enable = wr_data; // R4
			end else if (addr == ADDR_FAST_ENABLE) begin
				nxt_st.fast_enable = wr_data; // R7
			end else if (addr == ADDR_FORCE_LOWER) begin
				nxt_st.force_lower = wr_data; // R13
			end else if (addr == ADDR_FORCE_UPPER) begin
				nxt_st.force_upper = wr_data[UPPER_SRC-1:0];
			end else if (addr == ADDR_IRQ_MASK) begin
				nxt_st.mask = wr_data[EV_W-1:0];
			end else if (sel_hit) begin
				for (int k = 0; k < SEL_PER_WORD; k++) begin
					src = int'(sel_idx) * SEL_PER_WORD + k;
					if (src < NUM_SRC) begin
						nxt_st.level_select[src] =
							wr_data[k*BYTE_W +: LVL_W]; // R12
					end
				end
			end
		end

		// pending vectors rebuilt each cycle from live inputs
		nxt_st.level_pending  = lvl_hit; // R1 R9 R14
		// enable taken from the register, so a new enable acts next edge
		nxt_st.normal_pending = st_ff.normal_enable & lvl_hit; // R6 R10
		nxt_st.fast_pending   = st_ff.fast_enable & lvl_hit; // R10
		nxt_st.fast_req       = |nxt_st.fast_pending; // R8
		nxt_st.normal_req     = (|nxt_st.normal_pending) &&
			!(|nxt_st.fast_pending); // R5 R11

		// read data, one cycle after the strobe
		if (rd_en) begin
			if (addr == ADDR_LEVEL_PENDING) begin
				rword = st_ff.level_pending; // R9
			end else if (addr == ADDR_NORMAL_ENABLE) begin
				rword = st_ff.normal_enable;
			end else if (addr == ADDR_NORMAL_PEND) begin
				rword = st_ff.normal_pending; // R9
			end else if (addr == ADDR_FAST_ENABLE) begin
				rword = st_ff.fast_enable;
			end else if (addr == ADDR_FAST_PEND) begin
				rword = st_ff.fast_pending;
			end else if (addr == ADDR_FORCE_LOWER) begin
				rword = st_ff.force_lower;
			end else if (addr == ADDR_FORCE_UPPER) begin
				rword[UPPER_SRC-1:0] = st_ff.force_upper;
			end else if (addr == ADDR_IRQ_STATUS) begin
				rword[EV_W-1:0] = st_ff.status;
			end else if (addr == ADDR_IRQ_MASK) begin
				rword[EV_W-1:0] = st_ff.mask;
			end else if (sel_hit) begin
				for (int k = 0; k < SEL_PER_WORD; k++) begin
					src = int'(sel_idx) * SEL_PER_WORD + k;
					if (src < NUM_SRC) begin
						rword[k*BYTE_W +: LVL_W] = st_ff.level_select[src];
					end
				end
			end
		end
		nxt_st.rd_data = rword;

		// sticky events: read clears, a same-cycle rise still sets
		ev[EV_FAST_RISE]   = nxt_st.fast_req && !st_ff.fast_req;
		ev[EV_NORMAL_RISE] = nxt_st.normal_req && !st_ff.normal_req;
		if (rd_en && addr == ADDR_IRQ_STATUS) begin
			nxt_st.status = ev;
		end else begin
			nxt_st.status = st_ff.status | ev;
		end
		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0; // R4 R7 R12
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_level_clear: assert property (@(posedge clk) disable iff (sys_rst) // R1
		(eff_req == '0) |=> (st_ff.level_pending == '0))
		else $error("level pending set with no request");

	chk_level_index: assert property (@(posedge clk) disable iff (sys_rst) // R2
		eff_req[0] |=> st_ff.level_pending[$past(st_ff.level_select[0])])
		else $error("request not seen at its selected level");

	chk_ro_write: assert property (@(posedge clk) disable iff (sys_rst) // R3
		(wr_en && (addr == ADDR_LEVEL_PENDING || addr == ADDR_NORMAL_PEND ||
		addr == ADDR_FAST_PEND)) |=> ($stable(st_ff.normal_enable) &&
		$stable(st_ff.fast_enable) && $stable(st_ff.mask)))
		else $error("write to pending register changed state");

	chk_nen_write: assert property (@(posedge clk) disable iff (sys_rst) // R4
		(wr_en && addr == ADDR_NORMAL_ENABLE) |=>
		(st_ff.normal_enable == $past(wr_data)))
		else $error("normal enable not written");

	chk_normal_fire: assert property (@(posedge clk) disable iff (sys_rst) // R5
		(wr_en && addr == ADDR_NORMAL_ENABLE && (wr_data & lvl_hit) != '0
		&& st_ff.fast_enable == '0 && $stable(lvl_hit)) ##1 $stable(lvl_hit)
		|=> normal_req)
		else $error("enabled live level did not raise normal request");

	chk_np_and: assert property (@(posedge clk) disable iff (sys_rst) // R6 R10
		##1 (st_ff.normal_pending ==
		($past(st_ff.normal_enable) & st_ff.level_pending)))
		else $error("normal pending not enable AND level");

	chk_fen_write: assert property (@(posedge clk) disable iff (sys_rst) // R7
		(wr_en && addr == ADDR_FAST_ENABLE) |=>
		(st_ff.fast_enable == $past(wr_data)))
		else $error("fast enable not written");

	chk_fast_fire: assert property (@(posedge clk) disable iff (sys_rst) // R8
		(wr_en && addr == ADDR_FAST_ENABLE && (wr_data & lvl_hit) != '0)
		##1 $stable(lvl_hit) |=> fast_req)
		else $error("enabled live level did not raise fast request");

	chk_rd_pending: assert property (@(posedge clk) disable iff (sys_rst) // R9
		(rd_en && addr == ADDR_LEVEL_PENDING) |=>
		(rd_data == $past(st_ff.level_pending)))
		else $error("level pending read mismatch");

	chk_fast_wins: assert property (@(posedge clk) disable iff (sys_rst) // R11
		fast_req |-> !normal_req)
		else $error("normal request beside fast request");

	chk_force_or: assert property (@(posedge clk) disable iff (sys_rst) // R13
		st_ff.force_lower[0] |=>
		st_ff.level_pending[$past(st_ff.level_select[0])])
		else $error("force bit not seen at level");

	// irq follows status in the same edge, so a later read cannot mask it
	chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
		(fast_req && !$past(fast_req) && st_ff.mask[EV_FAST_RISE]) |-> irq)
		else $error("fast rise event did not raise irq");

	////////////////////////////////////////////////////////////////////////
	// register and status checks

	// holds: a stray address decode would show here first
	chk_nen_hold: assert property (@(posedge clk) disable iff (sys_rst) // R4
		!(wr_en && addr == ADDR_NORMAL_ENABLE) |=>
		$stable(st_ff.normal_enable))
		else $error("normal enable changed without a write");

	chk_fen_hold: assert property (@(posedge clk) disable iff (sys_rst) // R7
		!(wr_en && addr == ADDR_FAST_ENABLE) |=>
		$stable(st_ff.fast_enable))
		else $error("fast enable changed without a write");

	chk_rd_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!rd_en |=> (rd_data == '0))
		else $error("read data not zero outside a read");

	chk_rd_nen: assert property (@(posedge clk) disable iff (sys_rst) // R4
		(rd_en && addr == ADDR_NORMAL_ENABLE) |=>
		(rd_data == $past(st_ff.normal_enable)))
		else $error("normal enable read mismatch");

	chk_rd_fen: assert property (@(posedge clk) disable iff (sys_rst) // R7
		(rd_en && addr == ADDR_FAST_ENABLE) |=>
		(rd_data == $past(st_ff.fast_enable)))
		else $error("fast enable read mismatch");

	chk_rd_npend: assert property (@(posedge clk) disable iff (sys_rst) // R9
		(rd_en && addr == ADDR_NORMAL_PEND) |=>
		(rd_data == $past(st_ff.normal_pending)))
		else $error("normal pending read mismatch");

	chk_rd_fpend: assert property (@(posedge clk) disable iff (sys_rst) // R10
		(rd_en && addr == ADDR_FAST_PEND) |=>
		(rd_data == $past(st_ff.fast_pending)))
		else $error("fast pending read mismatch");

	chk_fp_and: assert property (@(posedge clk) disable iff (sys_rst) // R10
		##1 (st_ff.fast_pending ==
		($past(st_ff.fast_enable) & st_ff.level_pending)))
		else $error("fast pending not enable AND level");

	chk_fast_ev: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(fast_req) |->
		st_ff.status[EV_FAST_RISE])
		else $error("fast rise not recorded in status");

	chk_normal_ev: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(normal_req) |->
		st_ff.status[EV_NORMAL_RISE])
		else $error("normal rise not recorded in status");

	// with no rise in the cycle after the status read, that read must leave status zero
	chk_ev_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(rd_en && addr == ADDR_IRQ_STATUS) ##1
		(!$rose(fast_req) && !$rose(normal_req)) |-> (st_ff.status == '0))
		else $error("status not cleared by its read");

	chk_ev_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff.status[EV_NORMAL_RISE] && !(rd_en && addr == ADDR_IRQ_STATUS))
		|=> st_ff.status[EV_NORMAL_RISE])
		else $error("status bit lost without a read");

	chk_upper_index: assert property (@(posedge clk) disable iff (sys_rst) // R2
		eff_req[NUM_SRC-1] |=>
		st_ff.level_pending[$past(st_ff.level_select[NUM_SRC-1])])
		else $error("top source not seen at its selected level");

	chk_force_hi: assert property (@(posedge clk) disable iff (sys_rst) // R13
		st_ff.force_upper[UPPER_SRC-1] |=>
		st_ff.level_pending[$past(st_ff.level_select[NUM_SRC-1])])
		else $error("upper force bit not seen at level");

	chk_sel_write: assert property (@(posedge clk) disable iff (sys_rst) // R12
		(wr_en && addr == ADDR_SEL_FIRST) |=>
		(st_ff.level_select[0] == $past(wr_data[LVL_W-1:0])))
		else $error("level select not written");

	chk_sel_hold: assert property (@(posedge clk) disable iff (sys_rst) // R12
		!(wr_en && sel_hit) |=> $stable(st_ff.level_select))
		else $error("level select changed without a write");

	chk_force_write: assert property (@(posedge clk) disable iff (sys_rst) // R13
		(wr_en && addr == ADDR_FORCE_LOWER) |=>
		(st_ff.force_lower == $past(wr_data)))
		else $error("force lower not written");

	chk_mask_write: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_en && addr == ADDR_IRQ_MASK) |=>
		(st_ff.mask == $past(wr_data[EV_W-1:0])))
		else $error("irq mask not written");

	// pending may lag its cause by one edge and never more
	chk_pend_fresh: assert property (@(posedge clk) disable iff (sys_rst) // R14
		(st_ff.level_pending != '0) |-> ($past(eff_req) != '0))
		else $error("level pending outlived its request");

endmodule

// *** tb/plpe_src_model.sv ***
`timescale 1ns/1ps
// source side: each request is a held level, dropped only when told to
module plpe_src_model #(
	parameter int N = 40
) (
	// clock
	input  wire logic         clk,
	// wanted request levels
	input  wire logic [N-1:0] want,
	// requests into the block
	output logic      [N-1:0] src_req
);
	always @(posedge clk) begin
		src_req <= want;
	end
endmodule

// *** tb/priority_level_pending_enable_test.sv ***
`timescale 1ns/1ps
module priority_level_pending_enable_test;
	import plpe_pkg::*;
	logic        clk, sys_rst, wr_en, rd_en;
	logic        rd_q = 1'b0;
	logic        fast_req, normal_req, irq;
	logic [31:0] addr, wr_data, rd_data, d, ne, fe, lp;
	logic [39:0] want, src_req, sv;
	logic [4:0]  lvl [40];
	logic [31:0] expq [$];
	logic [31:0] ra [7];
	int          bad_count, samples_checked;

	plpe_src_model #(.N(40)) src_u (.clk(clk), .want(want), .src_req(src_req));
	priority_level_pending_enable #(.NUM_SRC(40)) dut_u (.clk(clk),
		.sys_rst(sys_rst), .src_req(src_req), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.fast_req(fast_req), .normal_req(normal_req), .irq(irq));

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		// a read whose data never got compared counts against the run
		bad_count += expq.size();
		$display("mismatches %0d of %0d checks", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// expectation queued at issue, compared by the watcher below
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		expq.push_back(e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	task automatic req(input logic f, input logic n);
		@(negedge clk);
		chk({30'h0, fast_req, normal_req}, {30'h0, f, n});
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rd_q)
			chk(rd_data, expq.pop_front());
		rd_q <= rd_en;
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		sys_rst = 1'b1;
		{wr_en, rd_en, addr, wr_data, want} = '0;
		ra = '{ADDR_LEVEL_PENDING, ADDR_NORMAL_PEND, ADDR_FAST_PEND,
			ADDR_IRQ_STATUS, ADDR_NORMAL_ENABLE, ADDR_FAST_ENABLE,
			32'h00c50030};
		void'($urandom(32));
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (ra[j])
			rd(ra[j], 32'h0);
		want <= 40'h20;
		repeat (3) @(posedge clk);
		rd(ADDR_LEVEL_PENDING, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h3);
		rd(ADDR_IRQ_MASK, 32'h3);
		wr(ADDR_FAST_ENABLE, 32'h1);
		req(1'b0, 1'b0);
		req(1'b1, 1'b0);
		wr(ADDR_NORMAL_ENABLE, 32'h1);
		req(1'b1, 1'b0);
		req(1'b1, 1'b0);
		rd(ADDR_NORMAL_PEND, 32'h1);
		for (int j = 0; j < 4; j++)
			wr(ra[j], 32'hffffffff);
		for (int j = 0; j < 3; j++)
			rd(ra[j], 32'h1);
		wr(ADDR_FAST_ENABLE, 32'h0);
		req(1'b1, 1'b0);
		req(1'b0, 1'b1);
		chk({31'h0, irq}, 32'h1);
		rd(ADDR_IRQ_STATUS, 32'h3);
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		// source gone, force alone must keep the level alive
		want <= '0;
		wr(ADDR_FORCE_LOWER, 32'h8);
		rd(ADDR_LEVEL_PENDING, 32'h1);
		wr(ADDR_FORCE_UPPER, 32'h80);
		rd(ADDR_FORCE_UPPER, 32'h80);
		wr(ADDR_FORCE_LOWER, 32'h0);
		rd(ADDR_LEVEL_PENDING, 32'h1);
		wr(ADDR_FORCE_UPPER, 32'h0);
		rd(ADDR_LEVEL_PENDING, 32'h0);
		// odd rounds crowd sources onto four levels
		for (int i = 0; i < 8; i++) begin
			for (int w = 0; w < 10; w++) begin
				d = $urandom & (i[0] ? 32'h03030303 : 32'hffffffff);
				wr(ADDR_SEL_FIRST + 4 * w, d);
				for (int k = 0; k < 4; k++)
					lvl[4 * w + k] = d[8 * k +: 5];
				rd(ADDR_SEL_FIRST + 4 * w, d & 32'h1f1f1f1f);
			end
			sv = (40'h1 << ($urandom % 40)) | (40'h1 << ($urandom % 40));
			sv = sv | (40'h1 << ($urandom % 40));
			want <= sv;
			ne = $urandom;
			fe = i[1] ? $urandom : 32'h0;
			// sources settle first, so enables meet live levels
			repeat (3) @(posedge clk);
			wr(ADDR_NORMAL_ENABLE, ne);
			wr(ADDR_FAST_ENABLE, fe);
			lp = 32'h0;
			for (int s = 0; s < 40; s++)
				if (sv[s])
					lp[lvl[s]] = 1'b1;
			rd(ADDR_LEVEL_PENDING, lp);
			rd(ADDR_NORMAL_PEND, ne & lp);
			rd(ADDR_FAST_PEND, fe & lp);
			req(|(fe & lp), |(ne & lp) & ~|(fe & lp));
		end
		// let the watcher take the last read before closing
		repeat (2) @(posedge clk);
		summarize();
	end
endmodule
